// [alu_ops_pkg.sv]
// Constants and types for the rotate, subtract and sleep execution block
// Functional notes
// - Right rotate through carry, bit 0 out
// - Destination bit: 0 to accumulator, 1 to file
// - Literal minus accumulator, carry and nibble carry
// - Subtract writes accumulator, updates carry, nibble, zero
// - Sleep clears power-down flag, sets time-out flag
// - Sleep clears watchdog counter and its prescaler
// - Sleep then halts with oscillator stopped
`default_nettype none
package alu_ops_pkg;

  // Instruction codes from the decoder
  typedef enum logic [1:0]
  {
    rotate_left_carry_op,
    rotate_right_carry_op,
    literal_minus_acc_op,
    sleep_op
  } op_t;

  // One decoded instruction with its file operand
  typedef struct packed
  {
    op_t        op;
    logic [6:0] faddr;
    logic       dest;
    logic [7:0] lit;
    logic [7:0] fdata;
  } instr_t;

  // Write port towards the file registers
  typedef struct packed
  {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } file_wr_t;

  // Core clock
  localparam int CLK_PERIOD_NS = 50;

  // Bus layout
  localparam int         AXI_AW    = 8;
  localparam logic [7:0] ACC_ADDR  = 8'h00;
  localparam logic [7:0] STAT_ADDR = 8'h04;

  // Status word bit positions
  localparam int ST_C    = 0;
  localparam int ST_NIB  = 1;
  localparam int ST_Z    = 2;
  localparam int ST_PWDN = 3;
  localparam int ST_TMO  = 4;
  localparam int ST_SLP  = 5;

  // Reset values and encodings
  localparam logic [7:0] ACC_RST  = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic       PWDN_RST = 1'b1;
  localparam logic       TMO_RST  = 1'b1;
  localparam logic       DEST_ACC = 1'b0;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage
`default_nettype wire

// [alu_ops.sv]
// Rotate, literal subtract and sleep execution with AXI4-Lite status access
`timescale 1ns/1ps
`default_nettype none
module alu_ops
  import alu_ops_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Decoded instruction
  input  wire logic              instr_valid,
  input  wire instr_t            instr,
  // Wake-up request from outside
  input  wire logic              wake_pin,
  // AXI4-Lite write address and data
  input  wire logic [AXI_AW-1:0] s_awaddr,
  input  wire logic              s_awvalid,
  output var  logic              s_awready,
  input  wire logic [31:0]       s_wdata,
  input  wire logic [3:0]        s_wstrb,
  input  wire logic              s_wvalid,
  output var  logic              s_wready,
  // AXI4-Lite write response
  output var  logic [1:0]        s_bresp,
  output var  logic              s_bvalid,
  input  wire logic              s_bready,
  // AXI4-Lite read
  input  wire logic [AXI_AW-1:0] s_araddr,
  input  wire logic              s_arvalid,
  output var  logic              s_arready,
  output var  logic [31:0]       s_rdata,
  output var  logic [1:0]        s_rresp,
  output var  logic              s_rvalid,
  input  wire logic              s_rready,
  // Results towards the core
  output var  file_wr_t          file_wr,
  output var  logic [7:0]        acc_value,
  output var  logic              wdt_clear,
  output var  logic              wdt_prescale_clear,
  output var  logic              osc_stop
);

  // Rotate through carry: returns {new carry, result}
  function automatic logic [8:0] rotate(input logic left,
                                        input logic cin,
                                        input logic [7:0] v);
    if (left)
      rotate = {v[7], v[6:0], cin};
    else
      rotate = {v[0], cin, v[7:1]};
  endfunction

  // Status word as software sees it
  function automatic logic [31:0] stat_word(input logic c,
                                            input logic nib,
                                            input logic z,
                                            input logic pwdn,
                                            input logic tmo,
                                            input logic slp);
    stat_word = WORD_ZERO;
    stat_word[ST_C] = c;
    stat_word[ST_NIB] = nib;
    stat_word[ST_Z] = z;
    stat_word[ST_PWDN] = pwdn;
    stat_word[ST_TMO] = tmo;
    stat_word[ST_SLP] = slp;
  endfunction

  logic       carry_q;
  logic       nibble_carry_flag_q;
  logic       zero_q;
  logic       power_down_flag_q;
  logic       time_out_flag_q;
  logic       sleep_q;
  logic [7:0] acc_q;
  logic       wake_meta_q;
  logic       wake_sync_q;
  logic       exec;
  logic       bus_wr;
  logic [8:0] rot;
  logic [7:0] diff;

  // Instructions run only while awake
  assign exec = instr_valid && !sleep_q;
  assign rot = rotate(instr.op == rotate_left_carry_op, carry_q,
                      instr.fdata);
  assign diff = instr.lit - acc_q;
  assign bus_wr = s_awready && s_awvalid && s_wready && s_wvalid;

  // Wake pin synchroniser
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wake_meta_q <= 1'b0;
      wake_sync_q <= 1'b0;
    end
    else
    begin
      wake_meta_q <= wake_pin;
      wake_sync_q <= wake_meta_q;
    end
  end

  // Accumulator: instruction result beats a bus write
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      acc_q <= ACC_RST;
    else if (exec && instr.op == literal_minus_acc_op)
      acc_q <= diff;
    else if (exec && instr.op != sleep_op && instr.dest == DEST_ACC)
      acc_q <= rot[7:0];
    else if (bus_wr && s_awaddr == ACC_ADDR && s_wstrb[0])
      acc_q <= s_wdata[7:0];
  end

  // Arithmetic flags: instruction update beats a bus write
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      carry_q <= 1'b0;
      nibble_carry_flag_q <= 1'b0;
      zero_q <= 1'b0;
    end
    else if (exec && instr.op == literal_minus_acc_op)
    begin
      carry_q <= (acc_q <= instr.lit);
      nibble_carry_flag_q <= (acc_q[3:0] <= instr.lit[3:0]);
      zero_q <= diff == BYTE_ZERO;
    end
    else if (exec && instr.op != sleep_op)
      carry_q <= rot[8];
    else if (bus_wr && s_awaddr == STAT_ADDR && s_wstrb[0])
    begin
      carry_q <= s_wdata[ST_C];
      nibble_carry_flag_q <= s_wdata[ST_NIB];
      zero_q <= s_wdata[ST_Z];
    end
  end

  // Power status flags, both read as one after reset
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      power_down_flag_q <= PWDN_RST;
      time_out_flag_q <= TMO_RST;
    end
    else if (exec && instr.op == sleep_op)
    begin
      power_down_flag_q <= 1'b0;
      time_out_flag_q <= 1'b1;
    end
  end

  // Sleep state, entered on the instruction, left on wake
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      sleep_q <= 1'b0;
    else if (exec && instr.op == sleep_op)
      sleep_q <= 1'b1;
    else if (wake_sync_q)
      sleep_q <= 1'b0;
  end

  // Registered outputs towards the core
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      file_wr <= '0;
      wdt_clear <= 1'b0;
      wdt_prescale_clear <= 1'b0;
    end
    else
    begin
      file_wr.we <= exec && instr.op inside {rotate_left_carry_op,
        rotate_right_carry_op} && instr.dest != DEST_ACC;
      file_wr.addr <= instr.faddr;
      file_wr.data <= rot[7:0];
      wdt_clear <= exec && instr.op == sleep_op;
      wdt_prescale_clear <= exec && instr.op == sleep_op;
    end
  end

  assign acc_value = acc_q;
  assign osc_stop = sleep_q;

  // Write channel: take address and data together, then respond
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OK;
    end
    else if (bus_wr)
    begin
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b1;
      s_bresp <= (s_awaddr == ACC_ADDR || s_awaddr == STAT_ADDR)
                 ? RESP_OK : RESP_ERR;
    end
    else if (s_bvalid)
      s_bvalid <= !s_bready;
    else if (s_awvalid && s_wvalid && !s_awready)
    begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
    end
  end

  // Read channel: one read at a time
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= WORD_ZERO;
      s_rresp <= RESP_OK;
    end
    else if (s_arready && s_arvalid)
    begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rresp <= RESP_OK;
      if (s_araddr == ACC_ADDR)
        s_rdata <= {24'h00_0000, acc_q};
      else if (s_araddr == STAT_ADDR)
        s_rdata <= stat_word(carry_q, nibble_carry_flag_q, zero_q,
                             power_down_flag_q, time_out_flag_q, sleep_q);
      else
      begin
        s_rdata <= WORD_ZERO;
        s_rresp <= RESP_ERR;
      end
    end
    else if (s_rvalid)
      s_rvalid <= !s_rready;
    else if (s_arvalid && !s_arready)
      s_arready <= 1'b1;
  end

  // Checks on the execution behaviour
  logic is_rotl;
  logic is_rotr;
  logic is_sub;
  logic is_slp;
  assign is_rotl = exec && instr.op == rotate_left_carry_op;
  assign is_rotr = exec && instr.op == rotate_right_carry_op;
  assign is_sub = exec && instr.op == literal_minus_acc_op;
  assign is_slp = exec && instr.op == sleep_op;

  a_rotr_value: assert property (@(posedge clk) disable iff (rst)
    is_rotr && instr.dest |=> file_wr.we &&
    file_wr.data == {$past(carry_q), $past(instr.fdata[7:1])} &&
    carry_q == $past(instr.fdata[0]))
    else $error("right rotate result wrong");

  a_rot_dest_acc: assert property (@(posedge clk) disable iff (rst)
    (is_rotl || is_rotr) && !instr.dest |=> !file_wr.we &&
    acc_q == ($past(is_rotl) ? {$past(instr.fdata[6:0]), $past(carry_q)}
                             : {$past(carry_q), $past(instr.fdata[7:1])}))
    else $error("rotate to accumulator wrong");

  a_rot_dest_file: assert property (@(posedge clk) disable iff (rst)
    (is_rotl || is_rotr) && instr.dest &&
    !(bus_wr && s_awaddr == ACC_ADDR) |=> file_wr.we &&
    file_wr.addr == $past(instr.faddr) && $stable(acc_q))
    else $error("rotate to file wrong");

  a_sub_flags: assert property (@(posedge clk) disable iff (rst)
    is_sub |=> carry_q == ($past(acc_q) <= $past(instr.lit)) &&
    nibble_carry_flag_q == ($past(acc_q[3:0]) <= $past(instr.lit[3:0])))
    else $error("subtract flags wrong");

  a_sub_result: assert property (@(posedge clk) disable iff (rst)
    is_sub |=> acc_q == 8'($past(instr.lit) - $past(acc_q)) &&
    zero_q == (acc_q == BYTE_ZERO))
    else $error("subtract result wrong");

  a_sleep_flags: assert property (@(posedge clk) disable iff (rst)
    is_slp |=> !power_down_flag_q && time_out_flag_q)
    else $error("sleep status flags wrong");

  a_wdt_clear: assert property (@(posedge clk) disable iff (rst)
    is_slp |=> wdt_clear && wdt_prescale_clear ##1 !wdt_clear)
    else $error("watchdog clear pulse wrong");

  a_osc_halt: assert property (@(posedge clk) disable iff (rst)
    is_slp ##1 !wake_sync_q |=> osc_stop)
    else $error("oscillator not stopped");

  a_rotl_value: assert property (@(posedge clk) disable iff (rst)
    is_rotl |=> file_wr.data == {$past(instr.fdata[6:0]),
    $past(carry_q)} && carry_q == $past(instr.fdata[7]))
    else $error("left rotate result wrong");

  c_rotate_file: cover property (@(posedge clk) is_rotl && instr.dest);
  c_subtract: cover property (@(posedge clk) is_sub && diff == BYTE_ZERO);
  c_sleep_wake: cover property (@(posedge clk) is_slp ##[1:20] !sleep_q);

endmodule
`default_nettype wire

// [test_rotate_subtract_sleep_ops.sv]
// Self-checking testbench for the rotate, subtract and sleep block
`timescale 1ns/1ps
`default_nettype none
module test_rotate_subtract_sleep_ops
  import alu_ops_pkg::*;
;
  logic        clk;
  logic        rst;
  logic        instr_valid;
  instr_t      instr;
  logic        wake_pin;
  logic [7:0]  s_awaddr;
  logic        s_awvalid;
  logic        s_awready;
  logic [31:0] s_wdata;
  logic [3:0]  s_wstrb;
  logic        s_wvalid;
  logic        s_wready;
  logic [1:0]  s_bresp;
  logic        s_bvalid;
  logic        s_bready;
  logic [7:0]  s_araddr;
  logic        s_arvalid;
  logic        s_arready;
  logic [31:0] s_rdata;
  logic [1:0]  s_rresp;
  logic        s_rvalid;
  logic        s_rready;
  file_wr_t    file_wr;
  logic [7:0]  acc_value;
  logic        wdt_clear;
  logic        wdt_prescale_clear;
  logic        osc_stop;
  int          mismatches = 0;
  int          checked = 0;
  int          cyc = 0;
  logic [31:0] d;
  logic [1:0]  r;

  // Block under test
  alu_ops alu_ops_i (.clk(clk), .rst(rst), .instr_valid(instr_valid),
    .instr(instr), .wake_pin(wake_pin), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .file_wr(file_wr), .acc_value(acc_value),
    .wdt_clear(wdt_clear), .wdt_prescale_clear(wdt_prescale_clear),
    .osc_stop(osc_stop));

  // Clock generation
  initial
  begin
    clk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) clk = ~clk;
  end

  task automatic print_verdict();
    if (mismatches == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Hang guard, far above the expected run length
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic cmp(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // Bus write; address and data offered together, each freed when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                        output logic [1:0] resp);
    @(posedge clk);
    s_awaddr  <= a;
    s_wdata   <= v;
    s_awvalid <= 1'b1;
    s_wvalid  <= 1'b1;
    s_bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_awready)
        s_awvalid <= 1'b0;
      if (s_wready)
        s_wvalid <= 1'b0;
    end
    while (s_bvalid !== 1'b1);
    resp = s_bresp;
    s_bready <= 1'b0;
  endtask

  // Bus read
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                        output logic [1:0] resp);
    @(posedge clk);
    s_araddr  <= a;
    s_arvalid <= 1'b1;
    s_rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_arready)
        s_arvalid <= 1'b0;
    end
    while (s_rvalid !== 1'b1);
    v = s_rdata;
    resp = s_rresp;
    s_rready <= 1'b0;
  endtask

  // One instruction; results are sampled just after the taking edge
  task automatic ex(input op_t o, input logic ds, input logic [7:0] l,
                    input logic [7:0] f);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr       <= '{o, 7'h2A, ds, l, f};
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  // Rotates through carry, both destinations, carry chained
  task automatic t_rotate();
    axi_wr(STAT_ADDR, 32'h0000_0000, r);
    cmp("wr ok", RESP_OK, r);
    ex(rotate_left_carry_op, 1'b0, 8'h00, 8'hE6);
    cmp("rl acc", 8'hCC, acc_value);
    cmp("rl we", 1'b0, file_wr.we);
    ex(rotate_right_carry_op, 1'b1, 8'h00, 8'h02);
    cmp("rr file", {1'b1, 7'h2A, 8'h81}, file_wr);
    cmp("rr acc", 8'hCC, acc_value);
    ex(rotate_right_carry_op, 1'b1, 8'h00, 8'h01);
    cmp("rr file", {1'b1, 7'h2A, 8'h00}, file_wr);
    ex(rotate_left_carry_op, 1'b1, 8'h00, 8'h80);
    cmp("rl file", {1'b1, 7'h2A, 8'h01}, file_wr);
    axi_rd(STAT_ADDR, d, r);
    cmp("carry", 1'b1, d[0]);
  endtask

  // Literal minus accumulator at equal, borrow and nibble boundaries
  task automatic t_sub();
    logic [7:0] av[4] = '{8'h05, 8'h06, 8'h1F, 8'h00};
    logic [7:0] lv[4] = '{8'h05, 8'h05, 8'h20, 8'hFF};
    logic [7:0] df;
    for (int i = 0; i < 4; i++)
    begin
      axi_wr(ACC_ADDR, {24'h00_0000, av[i]}, r);
      ex(literal_minus_acc_op, i[0], lv[i], 8'h00);
      df = lv[i] - av[i];
      cmp("sub acc", df, acc_value);
      cmp("sub we", 1'b0, file_wr.we);
      axi_rd(STAT_ADDR, d, r);
      cmp("sub flags", {df == 8'h00, av[i][3:0] <= lv[i][3:0],
          av[i] <= lv[i]}, d[2:0]);
    end
  endtask

  // Sleep entry, refusal while asleep, wake-up
  task automatic t_sleep();
    ex(sleep_op, 1'b0, 8'h00, 8'h00);
    cmp("wdt", 2'b11, {wdt_clear, wdt_prescale_clear});
    cmp("osc", 1'b1, osc_stop);
    @(posedge clk);
    #1;
    cmp("wdt pulse", 2'b00, {wdt_clear, wdt_prescale_clear});
    axi_rd(STAT_ADDR, d, r);
    cmp("sleep flags", 3'b110, d[5:3]);
    ex(rotate_left_carry_op, 1'b1, 8'h00, 8'hFF);
    cmp("asleep we", 1'b0, file_wr.we);
    @(posedge clk);
    wake_pin <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    cmp("wake", 1'b0, osc_stop);
    @(posedge clk);
    wake_pin <= 1'b0;
  endtask

  // Main sequence
  initial
  begin
    rst = 1'b1;
    instr_valid = 1'b0;
    instr = '0;
    wake_pin = 1'b0;
    s_awaddr = 8'h00;
    s_awvalid = 1'b0;
    s_wdata = 32'h0000_0000;
    s_wstrb = 4'h1;
    s_wvalid = 1'b0;
    s_bready = 1'b0;
    s_araddr = 8'h00;
    s_arvalid = 1'b0;
    s_rready = 1'b0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    axi_rd(STAT_ADDR, d, r);
    cmp("reset status", 32'h0000_0018, d);
    t_rotate();
    t_sub();
    t_sleep();
    axi_rd(8'h08, d, r);
    cmp("rd resp", RESP_ERR, r);
    axi_wr(8'h0C, 32'h0000_0000, r);
    cmp("wr resp", RESP_ERR, r);
    s_wstrb <= 4'h0;
    axi_wr(ACC_ADDR, 32'h0000_00A5, r);
    cmp("strobe resp", RESP_OK, r);
    s_wstrb <= 4'h1;
    axi_rd(ACC_ADDR, d, r);
    cmp("acc kept", 32'h0000_00FF, d);
    cmp("rd ok", RESP_OK, r);
    print_verdict();
  end
endmodule
`default_nettype wire
